// file: design/shared_sent_pkg.sv
// constants, field layout and carrier types for the shared sent addressing block
// assumes a 50 MHz ref_clk and a 12-bit register address equal to the printed offset
package shared_sent_pkg;

  // register offsets
  localparam logic [11:0] OFF_SHARED_PROTOCOL  = 12'h308;
  localparam logic [11:0] OFF_OUTPUT_SLOT      = 12'h317;
  localparam logic [11:0] OFF_ADDRESSING_SYNC  = 12'h319;
  localparam logic [11:0] OFF_LINK_STATUS      = 12'h320;

  // reset values
  localparam logic [23:0] RST_SHARED_PROTOCOL  = 24'h000000;
  localparam logic [23:0] RST_OUTPUT_SLOT      = 24'h000000;
  localparam logic [23:0] RST_ADDRESSING_SYNC  = 24'h000000;

  // shared_protocol_config fields
  localparam int PROTOCOL_MODE_LSB     = 0;
  localparam int HIGHEST_ID_LSB        = 16;
  localparam int PULSE_EXTEND_LSB      = 18;
  // output_slot_config fields
  localparam int SLOT_MARK_BIT         = 3;
  localparam int SENSOR_ID_LSB         = 4;
  // addressing_sync_config fields
  localparam int SAMPLE_ADDR_BIT       = 8;
  localparam int ZERO_SLOT_BIT         = 10;
  localparam int NO_SAMPLE_BIT         = 11;
  localparam int STAY_OFFLINE_BIT      = 19;
  localparam int IDLE_RESYNC_BIT       = 23;

  // protocol-select encodings
  localparam logic [2:0] MODE_ADDRESSABLE_SHARED = 3'h5;
  localparam logic [2:0] MODE_SEQUENTIAL_SHARED  = 3'h6;
  localparam logic [2:0] MODE_SEQUENTIAL_LONG    = 3'h7;

  // timing: tick length in ns and clock period in ns
  localparam int TICK_NS         = 3000;
  localparam int CLK_NS          = 20;
  localparam int TICK_CYCLES     = TICK_NS / CLK_NS;
  localparam int IDLE_LIMIT_TICKS = 510;

  // pulse widths in ticks
  localparam logic [7:0] OUT_MIN_TICKS    = 8'h09;
  localparam logic [7:0] OUT_MAX_TICKS    = 8'h11;
  localparam logic [7:0] SAMPLE_MIN_TICKS = 8'h12;
  localparam logic [7:0] SAMPLE_MAX_TICKS = 8'h1D;
  localparam logic [7:0] SYNC_MIN_TICKS   = 8'h1E;
  localparam logic [7:0] SYNC_MAX_TICKS   = 8'h3C;
  localparam logic [7:0] MARK_UNIT_TICKS  = 8'h04;

  // decoded configuration
  typedef struct packed {
    logic [2:0] protocol_mode;
    logic [1:0] highest_sensor_id;
    logic [1:0] output_pulse_min_extend;
    logic       slot_mark_enable;
    logic [1:0] sensor_id;
    logic       sample_addressing_select;
    logic       zero_slot_capture;
    logic       no_sample_hold;
    logic       stay_offline_after_reset;
    logic       idle_resync_enable;
  } sent_cfg_t;

  // one measured low pulse
  typedef struct packed {
    logic       done;
    logic [7:0] ticks;
  } line_pulse_t;

  typedef enum logic [1:0] {ST_WAIT_CFG, ST_OFFLINE, ST_ONLINE} link_state_t;

endpackage

// file: design/pin_sync.sv
// three-stage synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to ref_clk
module pin_sync #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  // clock and control
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic ce,
  // pin side
  input  wire logic pin_raw,
  output logic      pin_clean
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // the level changes only once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_r      <= IDLE_LEVEL;
      s2_r      <= IDLE_LEVEL;
      s3_r      <= IDLE_LEVEL;
      pin_clean <= IDLE_LEVEL;
    end else if (ce) begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) pin_clean <= s3_r;
    end
  end

endmodule // pin_sync

// file: design/pulse_meter.sv
// measures low pulses and idle time of the sent line in ticks
// assumes a clean synchronised line level, idle high
module pulse_meter #(
  parameter int TICK_CYCLES = shared_sent_pkg::TICK_CYCLES
) (
  // clock and control
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  // line
  input  wire logic                         line,
  // results
  output shared_sent_pkg::line_pulse_t      pulse,
  output logic                              tick,
  output logic                              idle_over
);

  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);
  localparam logic [9:0] IDLE_OVER = 10'(shared_sent_pkg::IDLE_LIMIT_TICKS + 1);

  initial begin
    if (TICK_CYCLES < 2) $error("pulse_meter: TICK_CYCLES must be at least 2");
  end

  logic [PW-1:0] pre_r;
  logic [9:0]    ticks_r;
  logic          prev_r;
  wire           edge_seen = (line != prev_r);
  wire           tick_now  = (pre_r == PRE_LAST);
  wire [7:0]     width_sat = (ticks_r > 10'h0FF) ? 8'hFF : ticks_r[7:0];

  // prescaler restarts on every transition so thresholds are exact to a tick
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_r     <= '0;
      ticks_r   <= 10'h000;
      prev_r    <= 1'b1;
      pulse     <= '0;
      tick      <= 1'b0;
      idle_over <= 1'b0;
    end else if (ce) begin
      prev_r     <= line;
      pulse.done <= edge_seen && line;    // rising edge ends a low pulse
      if (edge_seen && line) pulse.ticks <= width_sat;
      tick       <= tick_now && !edge_seen;
      idle_over  <= 1'b0;
      if (edge_seen) begin
        pre_r   <= '0;
        ticks_r <= 10'h000;
      end else if (tick_now) begin
        pre_r <= '0;
        if (ticks_r != 10'h3FF) ticks_r <= ticks_r + 10'h001;
        // fires once when idle passes the limit
        if (line && (ticks_r + 10'h001 == IDLE_OVER)) idle_over <= 1'b1;
      end else begin
        pre_r <= pre_r + PW'(1);
      end
    end
  end

endmodule // pulse_meter

// file: design/shared_sent_slot.sv
// slot counter, addressing and sample logic for a sensor on a shared sent line
// assumes a controller sending low function pulses and a loader raising cfg_ready
module shared_sent_slot #(
  parameter int TICK_CYCLES = shared_sent_pkg::TICK_CYCLES
) (
  // clock and control
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        cfg_ready,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [23:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [23:0] reg_rdata,
  // sent line
  input  wire logic        sent_line,
  // block results
  output logic             online,
  output logic      [1:0]  slot_count,
  output logic             sample_hold,
  output logic             output_request,
  output logic             mark_hold
);

  initial begin
    if (TICK_CYCLES < 2) $error("shared_sent_slot: TICK_CYCLES must be at least 2");
  end

  // configuration registers
  logic [23:0] shared_protocol_config_r;
  logic [23:0] output_slot_config_r;
  logic [23:0] addressing_sync_config_r;
  shared_sent_pkg::link_state_t state_r;
  shared_sent_pkg::link_state_t state_nxt;
  logic [7:0]  mark_left_r;
  logic [1:0]  slot_nxt;

  // line front end
  logic                          line_clean;
  shared_sent_pkg::line_pulse_t  pulse;
  logic                          tick;
  logic                          idle_over;

  pin_sync #(
    .IDLE_LEVEL (1'b1)
  ) u_sync (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .ce        (ce),
    .pin_raw   (sent_line),
    .pin_clean (line_clean)
  );

  pulse_meter #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_meter (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .ce        (ce),
    .line      (line_clean),
    .pulse     (pulse),
    .tick      (tick),
    .idle_over (idle_over)
  );

  // field decode
  shared_sent_pkg::sent_cfg_t cfg;
  assign cfg.protocol_mode =
    shared_protocol_config_r[shared_sent_pkg::PROTOCOL_MODE_LSB +: 3];
  assign cfg.highest_sensor_id =
    shared_protocol_config_r[shared_sent_pkg::HIGHEST_ID_LSB +: 2];
  assign cfg.output_pulse_min_extend =
    shared_protocol_config_r[shared_sent_pkg::PULSE_EXTEND_LSB +: 2];
  assign cfg.slot_mark_enable =
    output_slot_config_r[shared_sent_pkg::SLOT_MARK_BIT];
  assign cfg.sensor_id =
    output_slot_config_r[shared_sent_pkg::SENSOR_ID_LSB +: 2];
  assign cfg.sample_addressing_select =
    addressing_sync_config_r[shared_sent_pkg::SAMPLE_ADDR_BIT];
  assign cfg.zero_slot_capture =
    addressing_sync_config_r[shared_sent_pkg::ZERO_SLOT_BIT];
  assign cfg.no_sample_hold =
    addressing_sync_config_r[shared_sent_pkg::NO_SAMPLE_BIT];
  assign cfg.stay_offline_after_reset =
    addressing_sync_config_r[shared_sent_pkg::STAY_OFFLINE_BIT];
  assign cfg.idle_resync_enable =
    addressing_sync_config_r[shared_sent_pkg::IDLE_RESYNC_BIT];

  // protocol mode qualifiers
  wire seq_long   = (cfg.protocol_mode == shared_sent_pkg::MODE_SEQUENTIAL_LONG);
  wire seq_shared = seq_long ||
                    (cfg.protocol_mode == shared_sent_pkg::MODE_SEQUENTIAL_SHARED);

  // output pulse lower bound, extended only in long sequential mode
  wire [7:0] out_min = seq_long ?
    shared_sent_pkg::OUT_MIN_TICKS + {6'h00, cfg.output_pulse_min_extend}
    : shared_sent_pkg::OUT_MIN_TICKS;

  // pulse classification by width
  wire is_out    = pulse.done && (pulse.ticks >= out_min) &&
                   (pulse.ticks <= shared_sent_pkg::OUT_MAX_TICKS);
  wire is_sample = pulse.done && (pulse.ticks >= shared_sent_pkg::SAMPLE_MIN_TICKS) &&
                   (pulse.ticks <= shared_sent_pkg::SAMPLE_MAX_TICKS);
  wire is_sync   = pulse.done && (pulse.ticks >= shared_sent_pkg::SYNC_MIN_TICKS) &&
                   (pulse.ticks <= shared_sent_pkg::SYNC_MAX_TICKS);

  // slot events; with resync off an idle line has no effect at all
  wire idle_sync  = idle_over && cfg.idle_resync_enable;
  wire slot_sync  = is_sync || idle_sync;
  wire is_online  = (state_r == shared_sent_pkg::ST_ONLINE);
  wire addressed  = (slot_count == cfg.sensor_id);
  wire slot_wrap  = is_online && is_out && (slot_count == cfg.highest_sensor_id);
  wire slot_step  = is_online && is_out && !slot_wrap;
  wire slot_clear = slot_sync || slot_wrap;

  // next slot value
  always_comb begin
    slot_nxt = slot_count;
    if (slot_clear) slot_nxt = 2'h0;
    else if (slot_step) slot_nxt = slot_count + 2'h1;
  end

  // sample decision: broadcast or addressed pulse vetoed by no-sample, or zero-slot capture, which no-sample does not veto
  wire sample_by_pulse = is_online && is_sample && !cfg.no_sample_hold &&
                         (!cfg.sample_addressing_select || addressed);
  wire sample_by_zero  = slot_clear && cfg.zero_slot_capture && seq_shared &&
                         (is_online || state_nxt == shared_sent_pkg::ST_ONLINE);
  wire sample_nxt      = sample_by_pulse || sample_by_zero;

  // an addressing pulse starts the id-based high delay
  wire addr_pulse = is_online && (is_out || (is_sample && cfg.sample_addressing_select));
  wire mark_start = addr_pulse && cfg.slot_mark_enable && seq_shared;
  wire [7:0] mark_len =
    8'(({6'h00, cfg.sensor_id} + 8'h01) * shared_sent_pkg::MARK_UNIT_TICKS);

  // online state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      shared_sent_pkg::ST_WAIT_CFG: begin
        if (cfg_ready) begin
          if (cfg.stay_offline_after_reset) state_nxt = shared_sent_pkg::ST_OFFLINE;
          else state_nxt = shared_sent_pkg::ST_ONLINE;
        end
      end
      shared_sent_pkg::ST_OFFLINE: begin
        if (slot_sync) state_nxt = shared_sent_pkg::ST_ONLINE;
      end
      shared_sent_pkg::ST_ONLINE: state_nxt = shared_sent_pkg::ST_ONLINE;
      default: state_nxt = shared_sent_pkg::ST_WAIT_CFG;
    endcase
  end

  // register write decode
  wire wr_spc = reg_wr && (reg_addr == shared_sent_pkg::OFF_SHARED_PROTOCOL);
  wire wr_osc = reg_wr && (reg_addr == shared_sent_pkg::OFF_OUTPUT_SLOT);
  wire wr_asc = reg_wr && (reg_addr == shared_sent_pkg::OFF_ADDRESSING_SYNC);

  // read mux; unmapped addresses read zero
  wire [23:0] status_word = {19'h00000, mark_hold, state_r == shared_sent_pkg::ST_OFFLINE,
                             online, slot_count};
  wire [23:0] rd_mux =
    (reg_addr == shared_sent_pkg::OFF_SHARED_PROTOCOL) ? shared_protocol_config_r :
    (reg_addr == shared_sent_pkg::OFF_OUTPUT_SLOT)     ? output_slot_config_r :
    (reg_addr == shared_sent_pkg::OFF_ADDRESSING_SYNC) ? addressing_sync_config_r :
    (reg_addr == shared_sent_pkg::OFF_LINK_STATUS)     ? status_word : 24'h000000;

  // configuration registers and read data
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shared_protocol_config_r <= shared_sent_pkg::RST_SHARED_PROTOCOL;
      output_slot_config_r     <= shared_sent_pkg::RST_OUTPUT_SLOT;
      addressing_sync_config_r <= shared_sent_pkg::RST_ADDRESSING_SYNC;
      reg_rdata                <= 24'h000000;
    end else if (ce) begin
      if (wr_spc) shared_protocol_config_r <= reg_wdata;
      if (wr_osc) output_slot_config_r <= reg_wdata;
      if (wr_asc) addressing_sync_config_r <= reg_wdata;
      reg_rdata <= reg_rd ? rd_mux : 24'h000000;
    end
  end

  // slot counter, state and event outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r        <= shared_sent_pkg::ST_WAIT_CFG;
      slot_count     <= 2'h0;
      online         <= 1'b0;
      sample_hold    <= 1'b0;
      output_request <= 1'b0;
    end else if (ce) begin
      state_r        <= state_nxt;
      slot_count     <= slot_nxt;
      online         <= (state_nxt == shared_sent_pkg::ST_ONLINE);
      sample_hold    <= sample_nxt;
      output_request <= is_online && is_out && addressed;
    end
  end

  // slot-marking delay counted in ticks; a new addressing pulse restarts it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mark_left_r <= 8'h00;
      mark_hold   <= 1'b0;
    end else if (ce) begin
      if (mark_start) begin
        mark_left_r <= mark_len;
        mark_hold   <= 1'b1;
      end else if (tick && mark_left_r != 8'h00) begin
        mark_left_r <= mark_left_r - 8'h01;
        mark_hold   <= (mark_left_r != 8'h01);
      end
    end
  end

endmodule // shared_sent_slot

// file: test/sent_slot_asserts.sv
// port checks for the shared sent slot block
// assumes a bind from the bench top; config is shadowed from register writes
module sent_slot_asserts #(
  parameter int TICK_CYCLES = 150
) (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic        reg_wr,
  // line and results
  input wire logic        sent_line,
  input wire logic        online,
  input wire logic [1:0]  slot_count,
  input wire logic        sample_hold,
  input wire logic        output_request,
  input wire logic        mark_hold
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IDLE_LIM = 512 * TICK_CYCLES + 8;
  logic [23:0] proto_r, slot_r, sync_r;
  logic [19:0] idle_r;
  logic [15:0] mark_r;
  logic        line_r;
  int          mark_exp;

  // shadow config, so mode-gated outputs can be judged
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      proto_r <= 24'h000000;
      slot_r  <= 24'h000000;
      sync_r  <= 24'h000000;
    end else if (reg_wr) begin
      if (reg_addr == 12'h308) proto_r <= reg_wdata;
      if (reg_addr == 12'h317) slot_r <= reg_wdata;
      if (reg_addr == 12'h319) sync_r <= reg_wdata;
    end
  end

  // idle span on the raw pin; raw edge leads the clean one, hence the margin
  always_ff @(posedge ref_clk) begin
    line_r <= sent_line;
    if (rst || sent_line != line_r) idle_r <= 20'h00000;
    else if (idle_r != 20'hFFFFF) idle_r <= idle_r + 20'h00001;
    mark_r <= mark_hold ? mark_r + 16'h0001 : 16'h0000;
  end
  assign mark_exp = (int'(slot_r[5:4]) + 1) * 4 * TICK_CYCLES;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  idle_resync_a: assert property (
    sync_r[23] && idle_r == 20'(IDLE_LIM) |-> slot_count == 2'h0)
    else $error("slot not cleared after long idle");
  idle_hold_a: assert property (
    !sync_r[23] && idle_r == 20'(IDLE_LIM) |-> $stable(slot_count))
    else $error("slot moved on idle line");
  mark_mode_a: assert property (
    $rose(mark_hold) |-> slot_r[3] && proto_r[2:1] == 2'b11)
    else $error("marking outside sequential shared mode");
  mark_len_a: assert property (
    $fell(mark_hold) |-> mark_r >= 16'(mark_exp - TICK_CYCLES)
      && mark_r <= 16'(mark_exp + TICK_CYCLES))
    else $error("marking length not id based");
  offline_quiet_a: assert property (!online |-> !output_request)
    else $error("request while offline");
  slot_range_a: assert property (slot_count <= proto_r[17:16])
    else $error("slot above highest id");
  no_sample_a: assert property (sample_hold |-> !sync_r[11] || sync_r[10])
    else $error("sample while no-sample set");
  req_edge_a: assert property (output_request |-> idle_r < 20'h00010)
    else $error("request not tied to a pulse end");

  cover property (sample_hold);
  cover property (output_request);
  cover property ($rose(mark_hold));
  cover property ($rose(online));
endmodule // sent_slot_asserts

// file: test/sent_ctrl_model.sv
// controller model sending low function pulses on the shared line
// assumes the line idles high through a pull-up
module sent_ctrl_model #(
  parameter int TICK_CYCLES = 4
) (
  // clock
  input  wire logic ref_clk,
  // shared line
  output logic      sent_line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial sent_line = 1'b1;

  // low for n ticks plus half a tick, so width never sits on a tick edge
  task automatic pulse(input int n, input int gap);
    sent_line <= 1'b0;
    repeat (n * TICK_CYCLES + TICK_CYCLES / 2) @(posedge ref_clk);
    sent_line <= 1'b1;
    repeat (gap) @(posedge ref_clk);
  endtask
endmodule // sent_ctrl_model

// file: test/tb_top.sv
// self-checking bench for the shared sent slot block
// assumes the controller model and checker are compiled first
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 4;
  logic        ref_clk, rst, ce, cfg_ready, reg_wr, reg_rd, rd_pend;
  logic [11:0] reg_addr;
  logic [23:0] reg_wdata, reg_rdata;
  logic        online, sample_hold, output_request, mark_hold, seen;
  logic [1:0]  slot_count, ev;
  logic [7:0]  lfsr;
  logic [47:0] rn;
  wire logic   sent_line;
  logic [47:0] rdq[$];
  logic [1:0]  evq[$];
  int          error_cnt, checks;

  sent_ctrl_model #(.TICK_CYCLES(TC)) u_ctrl (.ref_clk(ref_clk), .sent_line(sent_line));
  shared_sent_slot #(.TICK_CYCLES(TC)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .cfg_ready(cfg_ready), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sent_line(sent_line), .online(online), .slot_count(slot_count),
    .sample_hold(sample_hold), .output_request(output_request), .mark_hold(mark_hold));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk_val(input string n, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_ev(input string n, input logic [1:0] e, input logic [1:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // watcher at the falling edge, where registered results have settled
  always @(negedge ref_clk) begin
    if (rd_pend && rdq.size() > 0) begin
      rn = rdq.pop_front();
      chk_val("reg_rdata", rn[23:0], reg_rdata & rn[47:24]);
    end
    rd_pend = reg_rd;
    if (sample_hold || output_request) begin
      ev = evq.size() > 0 ? evq.pop_front() : 2'b00;
      chk_ev("event", ev, {sample_hold, output_request});
    end
  end

  // register master: a spare cycle after each strobe avoids double drives
  task automatic wr(input logic [11:0] a, input logic [23:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [23:0] m, input logic [23:0] e);
    rdq.push_back({m, e & m});
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic cfg(input logic [23:0] p, input logic [23:0] s, input logic [23:0] y);
    wr(12'h308, p);
    wr(12'h317, s);
    wr(12'h319, y);
  endtask
  task automatic send(input int n, input logic [1:0] e);
    if (e != 2'b00) evq.push_back(e);
    u_ctrl.pulse(n, 16);
    chk_val("events_left", 24'h000000, 24'(evq.size()));
  endtask
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic samp(input logic [1:0] e);
    lfsr = nxt(lfsr);
    send(18 + int'(lfsr) % 12, e);
  endtask
  task automatic watch_mark(input logic e);
    seen = 1'b0;
    repeat (24 * TC) begin
      @(negedge ref_clk);
      seen = seen | mark_hold;
    end
    @(posedge ref_clk);
    chk_val("mark_hold", 24'(e), 24'(seen));
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    cfg_ready = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 24'h000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_pend = 1'b0;
    lfsr = 8'h2E;
    error_cnt = 0;
    checks = 0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    // reset values, an unmapped hole, random data through the fields
    rd(12'h308, 24'hFFFFFF, 24'h000000);
    rd(12'h317, 24'hFFFFFF, 24'h000000);
    rd(12'h319, 24'hFFFFFF, 24'h000000);
    rd(12'h123, 24'hFFFFFF, 24'h000000);
    lfsr = nxt(lfsr);
    wr(12'h319, {3{lfsr}});
    rd(12'h319, 24'h880D00, {3{lfsr}});
    // held offline until a sync pulse
    cfg(24'h010006, 24'h000010, 24'h080000);
    cfg_ready <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk_val("online", 24'h000000, 24'(online));
    send(10, 2'b00);
    send(40, 2'b00);
    chk_val("online", 24'h000001, 24'(online));
    // broadcast sampling, then blocked
    cfg(24'h010006, 24'h000010, 24'h000000);
    samp(2'b10);
    samp(2'b10);
    wr(12'h319, 24'h000800);
    samp(2'b00);
    // addressed sampling with marking, id 1 of two sensors
    cfg(24'h010006, 24'h000018, 24'h000100);
    samp(2'b00);
    // let the marking delay of the unaddressed sample run out before the next pulse
    repeat (10 * TC) @(posedge ref_clk);
    send(10, 2'b00);
    chk_val("slot", 24'h000001, 24'(slot_count));
    samp(2'b10);
    watch_mark(1'b1);
    send(10, 2'b01);
    wr(12'h317, 24'h000010);
    send(10, 2'b00);
    watch_mark(1'b0);
    send(10, 2'b01);
    // minimum output width per extend code in long mode
    for (int x = 0; x < 4; x++) begin
      cfg(24'h000007 | (24'(x) << 18), 24'h000000, 24'h000000);
      send(8 + x, 2'b00);
      send(9 + x, 2'b01);
    end
    cfg(24'h0C0006, 24'h000000, 24'h000000);
    send(9, 2'b01);
    // idle resync with zero-slot capture, then resync off
    cfg(24'h010006, 24'h000010, 24'h800400);
    send(10, 2'b00);
    evq.push_back(2'b10);
    repeat (520 * TC) @(posedge ref_clk);
    chk_val("slot", 24'h000000, 24'(slot_count));
    chk_val("events_left", 24'h000000, 24'(evq.size()));
    wr(12'h319, 24'h000400);
    send(10, 2'b00);
    repeat (520 * TC) @(posedge ref_clk);
    chk_val("slot", 24'h000001, 24'(slot_count));
    // fresh reset with offline bit clear
    rst <= 1'b1;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk_val("online", 24'h000001, 24'(online));
    chk_val("slot", 24'h000000, 24'(slot_count));
    print_verdict();
  end

  // hang guard, far above the expected run of about 6200 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    error_cnt++;
    print_verdict();
  end
endmodule // tb_top

bind shared_sent_slot sent_slot_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .sent_line(sent_line), .online(online), .slot_count(slot_count),
  .sample_hold(sample_hold), .output_request(output_request), .mark_hold(mark_hold));
